// file: rmf_ack_timer.sv
// Reply timing: fixed delay after frame end, or next slot boundary aligned to SFD.
// Assumes rx_sfd and rx_end are one-cycle pulses from the receiver.
`include "rmf_consts.svh"
module rmf_ack_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // Control
  input wire logic slotted,
  input wire logic rx_sfd,
  input wire logic arm,
  // Reply start pulse
  output logic fire
);
  import rmf_pkg::*;

  logic [11:0] slot_pos; // Cycles since SFD, modulo one slot
  logic [11:0] since_end; // Cycles since frame end, saturating
  logic armed; // Waiting to send a reply
  logic due; // Reply moment reached

  // Slot phase: restarted at every SFD so slots line up with it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slot_pos <= 12'h000;
    end else if (ce) begin
      if (rx_sfd || slot_pos == 12'(`RMF_SLOT_CYC - 1)) begin
        slot_pos <= 12'h000;
      end else begin
        slot_pos <= slot_pos + 12'h001;
      end
    end
  end

  // Elapsed time since end; slotted waits for a slot edge past the minimum
  assign due = slotted ? (since_end >= 12'(`RMF_ACK_CYC) && slot_pos == 12'h000)
                       : (since_end == 12'(`RMF_ACK_CYC));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
      since_end <= 12'h000;
      fire <= 1'b0;
    end else if (ce) begin
      fire <= 1'b0;
      if (arm) begin
        armed <= 1'b1;
        since_end <= 12'h001;
      end else if (armed) begin
        if (due) begin
          armed <= 1'b0;
          fire <= 1'b1;
        end else if (since_end != 12'hFFF) begin
          since_end <= since_end + 12'h001;
        end
      end
    end
  end

  property p_ack_fixed;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && armed && due && !slotted) |-> (since_end == 12'(`RMF_ACK_CYC));
  endproperty
  a_ack_fixed: assert property (p_ack_fixed) else $error("reply not at fixed delay");

  property p_ack_slot;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && armed && due && slotted) |-> (slot_pos == 12'h000 && since_end >= 12'(`RMF_ACK_CYC));
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("slotted reply misaligned");
endmodule // rmf_ack_timer

// file: rmf_consts.svh
// Constants of the radio modem frame control block: offsets, fields, resets, timing.
// Assumes a 10 MHz system clock and byte-wide data-memory register access.
// Functional notes
// - Frame-type alter: keep, invert, clear, set MSB
// - Received bytes reach the queue unmodified
// - Reserved types rejected when reserved-accept is 0
// - Reserved types accepted, no decoding, when set
// - Decoding off: every frame is received
// - Coordinator bit filters frames without destination
// - Address decoding only while enable bit is 1
// - Three-bit hysteresis in dB, reset 010
// - Assessment mode, reset 11; 01 compares below threshold
// - Auto checksum appended right after last byte
// - Auto checksum checked on every received frame
// - Auto reply 12 symbols after frame, unslotted
// - Slotted reply at first slot past 12 symbols
// - Preamble of setting plus one zero bytes
// - Reply SFD spacing whole multiples of 20 symbols
// - Signed 8-bit threshold, reset E0, compared
`ifndef RMF_CONSTS_SVH
`define RMF_CONSTS_SVH
// Control register offsets and reset values
`define RMF_FILT_ADDR 16'hDF02
`define RMF_FILT_RST 8'h0A
`define RMF_LINK_ADDR 16'hDF03
`define RMF_LINK_RST 8'hE2
`define RMF_CTLB_ADDR 16'hDF04
`define RMF_CTLB_RST 8'h30
`define RMF_THR_ADDR 16'hDF05
`define RMF_THR_RST 8'hE0
// Field positions
`define RMF_F_ALTER 7:6
`define RMF_F_RSVACC 5
`define RMF_F_COORD 4
`define RMF_F_DECODE 3
`define RMF_F_HYST 2:0
`define RMF_F_CCSEL 7:6
`define RMF_F_AUTO_CHECKSUM_ENABLE 5
`define RMF_F_AUTO_REPLY_ENABLE 4
`define RMF_F_PRELEN 3:0
`define RMF_F_SLOTTED 7
// Test registers: address list and reset list in the same order
`define RMF_TEST_NUM 19
`define RMF_TEST_ADDRS {16'hDF28, 16'hDF29, 16'hDF2A, 16'hDF2B, 16'hDF2C, 16'hDF2D, \
  16'hDF2E, 16'hDF2F, 16'hDF30, 16'hDF31, 16'hDF32, 16'hDF33, 16'hDF34, 16'hDF35, \
  16'hDF37, 16'hDF38, 16'hDF3F, 16'hDF40, 16'hDF41}
`define RMF_TEST_RSTS {8'h36, 8'h49, 8'h08, 8'h54, 8'h09, 8'h0A, 8'h10, 8'h00, 8'h40, \
  8'h32, 8'h20, 8'h00, 8'h92, 8'hDD, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}
// Frame type codes
`define RMF_FT_BEACON 3'h0
`define RMF_FT_DATA 3'h1
`define RMF_FT_ACK 3'h2
`define RMF_FT_CMD 3'h3
// Checksum: reflected ITU-T polynomial
`define RMF_CRC_POLY 16'h8408
// Timing
`define RMF_CLK_NS 100
`define RMF_SYMBOL_NS 16000
`define RMF_SYM_CYC (`RMF_SYMBOL_NS / `RMF_CLK_NS)
`define RMF_ACK_SYMS 12
`define RMF_SLOT_SYMS 20
`define RMF_ACK_CYC (`RMF_ACK_SYMS * `RMF_SYM_CYC)
`define RMF_SLOT_CYC (`RMF_SLOT_SYMS * `RMF_SYM_CYC)
`endif

// file: rmf_crc16.sv
// Byte-serial ITU-T CRC-16, LSB first, zero preset.
// Assumes bytes arrive one per enabled cycle on the system clock.
`include "rmf_consts.svh"
module rmf_crc16 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // Data
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  import rmf_pkg::*;

  // One byte through the reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `RMF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Running remainder; clear wins so a new frame never inherits old state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      crc <= 16'h0000;
    end else if (ce) begin
      if (clear) begin
        crc <= 16'h0000;
      end else if (en) begin
        crc <= crc_step(crc, data);
      end
    end
  end

  property p_crc_clear;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && clear) |=> (crc == 16'h0000);
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("checksum not cleared");
endmodule // rmf_crc16

// file: rmf_frame_ctrl.sv
// Modem frame control: registers, frame filter, checksum, channel assessment,
// reply timing and transmit preamble framing.
// Assumes same-clock receiver, modulator and data-memory access; no pins sampled.
`include "rmf_consts.svh"
module rmf_frame_ctrl (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // Register access in data memory space
  input wire rmf_pkg::rmf_xd_req_s xd_req,
  output logic [7:0] xd_rdata,
  // Receive byte stream
  input wire logic rx_sfd,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire rmf_pkg::rmf_rx_info_s rx_info,
  // Receive queue side
  output logic rx_q_valid,
  output logic [7:0] rx_q_byte,
  output rmf_pkg::rmf_rx_result_s rx_result,
  // Reply start
  output logic ack_start,
  // Channel assessment
  input wire logic ss_valid,
  input wire logic signed [7:0] signal_strength,
  input wire logic rx_active,
  output logic channel_clear_flag,
  // Transmit source
  input wire logic tx_start,
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_byte,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  // Modulator side
  input wire logic tx_take,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_sync_slot,
  output logic tx_underrun
);
  import rmf_pkg::*;

  // Control registers
  logic [7:0] modem_frame_filter_ctrl;
  logic [7:0] modem_link_ctrl;
  logic [7:0] modem_ctrl_b_hi;
  logic [7:0] channel_clear_threshold;
  logic [7:0] test_reg [`RMF_TEST_NUM]; // Analogue test bank, held only

  localparam logic [16*`RMF_TEST_NUM-1:0] TEST_ADDRS = `RMF_TEST_ADDRS;
  localparam logic [8*`RMF_TEST_NUM-1:0] TEST_RSTS = `RMF_TEST_RSTS;

  // Test bank lookup, used by both the read and the write path
  function automatic logic [5:0] test_hit(input logic [15:0] a);
    logic [5:0] r;
    r = 6'h3F;
    for (int i = 0; i < `RMF_TEST_NUM; i++) begin
      if (TEST_ADDRS[16*(`RMF_TEST_NUM-1-i) +: 16] == a) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // Frame type as the filter sees it; stored bytes are never touched
  function automatic logic [2:0] alter_type(input logic [1:0] m, input logic [2:0] t);
    logic [2:0] r;
    r = t;
    unique case (m)
      2'h0: r = t;
      2'h1: r = {~t[2], t[1:0]};
      2'h2: r = {1'b0, t[1:0]};
      2'h3: r = {1'b1, t[1:0]};
    endcase
    return r;
  endfunction

  // Field views
  logic [1:0] frame_type_alter;
  logic reserved_accept;
  logic coordinator_role;
  logic addr_decode;
  logic [2:0] channel_clear_hysteresis;
  logic [1:0] channel_clear_select;
  logic auto_checksum_enable;
  logic auto_reply_enable;
  logic [3:0] preamble_len;
  logic slotted_ack;

  assign frame_type_alter = modem_frame_filter_ctrl[`RMF_F_ALTER];
  assign reserved_accept = modem_frame_filter_ctrl[`RMF_F_RSVACC];
  assign coordinator_role = modem_frame_filter_ctrl[`RMF_F_COORD];
  assign addr_decode = modem_frame_filter_ctrl[`RMF_F_DECODE];
  assign channel_clear_hysteresis = modem_frame_filter_ctrl[`RMF_F_HYST];
  assign channel_clear_select = modem_link_ctrl[`RMF_F_CCSEL];
  assign auto_checksum_enable = modem_link_ctrl[`RMF_F_AUTO_CHECKSUM_ENABLE];
  assign auto_reply_enable = modem_link_ctrl[`RMF_F_AUTO_REPLY_ENABLE];
  assign preamble_len = modem_link_ctrl[`RMF_F_PRELEN];
  assign slotted_ack = modem_ctrl_b_hi[`RMF_F_SLOTTED];

  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  assign wr_idx = test_hit(xd_req.addr);
  assign rd_idx = wr_idx;

  // Register writes: every field holds its value until software writes it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modem_frame_filter_ctrl <= `RMF_FILT_RST;
      modem_link_ctrl <= `RMF_LINK_RST;
      modem_ctrl_b_hi <= `RMF_CTLB_RST;
      channel_clear_threshold <= `RMF_THR_RST;
    end else if (ce && xd_req.wr) begin
      unique case (xd_req.addr)
        `RMF_FILT_ADDR: modem_frame_filter_ctrl <= xd_req.wdata;
        `RMF_LINK_ADDR: modem_link_ctrl <= xd_req.wdata;
        `RMF_CTLB_ADDR: modem_ctrl_b_hi <= xd_req.wdata;
        `RMF_THR_ADDR: channel_clear_threshold <= xd_req.wdata;
        default: ; // Other addresses belong elsewhere
      endcase
    end
  end

  // Test bank writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `RMF_TEST_NUM; i++) begin
        test_reg[i] <= TEST_RSTS[8*(`RMF_TEST_NUM-1-i) +: 8];
      end
    end else if (ce && xd_req.wr && wr_idx != 6'h3F) begin
      test_reg[wr_idx[4:0]] <= xd_req.wdata;
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      xd_rdata <= 8'h00;
    end else if (ce && xd_req.rd) begin
      if (xd_req.addr == `RMF_FILT_ADDR) begin
        xd_rdata <= modem_frame_filter_ctrl;
      end else if (xd_req.addr == `RMF_LINK_ADDR) begin
        xd_rdata <= modem_link_ctrl;
      end else if (xd_req.addr == `RMF_CTLB_ADDR) begin
        xd_rdata <= modem_ctrl_b_hi;
      end else if (xd_req.addr == `RMF_THR_ADDR) begin
        xd_rdata <= channel_clear_threshold;
      end else if (rd_idx != 6'h3F) begin
        xd_rdata <= test_reg[rd_idx[4:0]];
      end else begin
        xd_rdata <= 8'h00;
      end
    end
  end

  // Frame filter decision, evaluated at frame end
  logic [2:0] eff_type;
  logic next_accept;
  assign eff_type = alter_type(frame_type_alter, rx_info.ftype);

  always_comb begin
    next_accept = 1'b1;
    if (!addr_decode) begin
      next_accept = 1'b1;
    end else if (eff_type[2]) begin
      next_accept = reserved_accept;
    end else if (eff_type == `RMF_FT_BEACON) begin
      next_accept = rx_info.src_pan_match;
    end else if (rx_info.dst_present) begin
      next_accept = rx_info.addr_match;
    end else if (eff_type == `RMF_FT_ACK) begin
      next_accept = 1'b1;
    end else begin
      // No destination: only a coordinator takes data and commands from its PAN
      next_accept = coordinator_role && rx_info.src_pan_match;
    end
  end

  // Receive checksum over data and trailing checksum; zero residue is valid
  logic rx_crc_clr;
  logic [15:0] rx_crc;
  assign rx_crc_clr = rx_sfd;

  rmf_crc16 u_rx_crc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .clear(rx_crc_clr),
    .en(rx_byte_valid),
    .data(rx_byte),
    .crc(rx_crc)
  );

  // Bytes pass to the queue exactly as received
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_q_valid <= 1'b0;
      rx_q_byte <= 8'h00;
    end else if (ce) begin
      rx_q_valid <= rx_byte_valid;
      if (rx_byte_valid) begin
        rx_q_byte <= rx_byte;
      end
    end
  end

  // Frame result; without auto checksum the frame is never deemed checked
  logic crc_good;
  logic ack_arm;
  assign crc_good = auto_checksum_enable && rx_crc == 16'h0000;
  assign ack_arm = ce && rx_end && auto_reply_enable && next_accept && rx_info.ack_req
                   && crc_good;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_result <= '0;
    end else if (ce) begin
      rx_result.done <= rx_end;
      if (rx_end) begin
        rx_result.accept <= next_accept;
        rx_result.crc_ok <= crc_good;
      end
    end
  end

  rmf_ack_timer u_ack (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .slotted(slotted_ack),
    .rx_sfd(rx_sfd),
    .arm(ack_arm),
    .fire(ack_start)
  );

  // Channel assessment with hysteresis: clear below thr-hyst, busy at thr
  logic signed [9:0] thr_low;
  logic signed [9:0] ss_wide;
  logic cc_level;
  assign thr_low = 10'(signed'(channel_clear_threshold)) - 10'(channel_clear_hysteresis);
  assign ss_wide = 10'(signal_strength);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cc_level <= 1'b0;
    end else if (ce && ss_valid) begin
      if (ss_wide < thr_low) begin
        cc_level <= 1'b1;
      end else if (ss_wide >= 10'(signed'(channel_clear_threshold))) begin
        cc_level <= 1'b0;
      end
    end
  end

  // Mode select: 00 reserved reads busy; upper modes also busy while receiving
  always_comb begin
    unique case (channel_clear_select)
      2'h0: channel_clear_flag = 1'b0;
      2'h1: channel_clear_flag = cc_level;
      2'h2: channel_clear_flag = cc_level && !rx_active;
      2'h3: channel_clear_flag = cc_level && !rx_active;
    endcase
  end

  // Transmit framer
  rmf_tx_state_e tx_state;
  logic [3:0] pre_left; // Preamble bytes still to send after this one
  logic tx_crc_clr;
  logic tx_crc_en;
  logic [15:0] tx_crc;
  logic in_data;
  logic last_q; // Current data byte is the final one
  assign in_data = tx_state == RMF_TX_SYNC || tx_state == RMF_TX_DATA;
  assign tx_in_ready = ce && tx_take && in_data && !(tx_state == RMF_TX_DATA && last_q);
  assign tx_valid = tx_state != RMF_TX_IDLE;
  assign tx_sync_slot = tx_state == RMF_TX_SYNC;
  assign tx_crc_clr = tx_start && tx_state == RMF_TX_IDLE;
  assign tx_crc_en = tx_in_ready && tx_in_valid;

  rmf_crc16 u_tx_crc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .clear(tx_crc_clr),
    .en(tx_crc_en),
    .data(tx_in_byte),
    .crc(tx_crc)
  );

  // Byte sequence: zeros, sync slot, data, then two checksum bytes when auto checksum is on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_state <= RMF_TX_IDLE;
      tx_byte <= 8'h00;
      pre_left <= 4'h0;
      last_q <= 1'b0;
      tx_underrun <= 1'b0;
    end else if (ce) begin
      tx_underrun <= 1'b0;
      unique case (tx_state)
        RMF_TX_IDLE: begin
          if (tx_start) begin
            tx_state <= RMF_TX_PRE;
            tx_byte <= 8'h00;
            pre_left <= preamble_len;
            last_q <= 1'b0;
          end
        end
        RMF_TX_PRE: begin
          if (tx_take) begin
            if (pre_left == 4'h0) begin
              tx_state <= RMF_TX_SYNC;
            end else begin
              pre_left <= pre_left - 4'h1;
            end
          end
        end
        RMF_TX_SYNC, RMF_TX_DATA: begin
          if (tx_take) begin
            if (tx_state == RMF_TX_DATA && last_q) begin
              // Checksum follows the final byte at once, or the frame ends
              if (auto_checksum_enable) begin
                tx_state <= RMF_TX_FCS_LO;
                tx_byte <= tx_crc[7:0];
              end else begin
                tx_state <= RMF_TX_IDLE;
              end
            end else if (tx_in_valid) begin
              tx_state <= RMF_TX_DATA;
              tx_byte <= tx_in_byte;
              last_q <= tx_in_last;
            end else begin
              // Source starved the modulator: abandon the frame
              tx_state <= RMF_TX_IDLE;
              tx_underrun <= 1'b1;
            end
          end
        end
        RMF_TX_FCS_LO: begin
          if (tx_take) begin
            tx_state <= RMF_TX_FCS_HI;
            tx_byte <= tx_crc[15:8];
          end
        end
        RMF_TX_FCS_HI: begin
          if (tx_take) begin
            tx_state <= RMF_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Helper: preamble bytes taken in this frame
  logic [4:0] pre_sent;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre_sent <= 5'h00;
    end else if (ce) begin
      if (tx_state == RMF_TX_IDLE) begin
        pre_sent <= 5'h00;
      end else if (tx_state == RMF_TX_PRE && tx_take) begin
        pre_sent <= pre_sent + 5'h01;
      end
    end
  end

  property p_preamble;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && tx_state == RMF_TX_PRE && tx_take && pre_left == 4'h0)
      |=> (pre_sent == 5'(preamble_len) + 5'h01);
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble length wrong");

  property p_alter;
    @(posedge clk_sys) disable iff (!rstn)
    (frame_type_alter == 2'h1) |-> (eff_type == {~rx_info.ftype[2], rx_info.ftype[1:0]});
  endproperty
  a_alter: assert property (p_alter) else $error("frame type not inverted");

  property p_passthru;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && rx_byte_valid) |=> (rx_q_valid && rx_q_byte == $past(rx_byte));
  endproperty
  a_passthru: assert property (p_passthru) else $error("queue byte altered");

  property p_rsv_reject;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && rx_end && addr_decode && eff_type[2] && !reserved_accept) |=> !rx_result.accept;
  endproperty
  a_rsv_reject: assert property (p_rsv_reject) else $error("reserved type accepted");

  property p_rsv_accept;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && rx_end && addr_decode && eff_type[2] && reserved_accept) |=> rx_result.accept;
  endproperty
  a_rsv_accept: assert property (p_rsv_accept) else $error("reserved type rejected");

  property p_no_decode;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && rx_end && !addr_decode) |=> (rx_result.done && rx_result.accept);
  endproperty
  a_no_decode: assert property (p_no_decode) else $error("frame dropped undecoded");

  property p_cca_clear;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && ss_valid && ss_wide < thr_low && channel_clear_select == 2'h1)
      |=> (channel_clear_flag || $past(channel_clear_select) != channel_clear_select);
  endproperty
  a_cca_clear: assert property (p_cca_clear) else $error("channel not reported clear");

  property p_fcs_follows;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && tx_state == RMF_TX_DATA && last_q && tx_take && auto_checksum_enable)
      |=> (tx_state == RMF_TX_FCS_LO && tx_byte == $past(tx_crc[7:0]));
  endproperty
  a_fcs_follows: assert property (p_fcs_follows) else $error("checksum not appended");
endmodule // rmf_frame_ctrl

// file: rmf_pkg.sv
// Types shared by the radio modem frame control block.
// Assumes rmf_consts.svh for all numeric constants.
package rmf_pkg;
  // Byte-wide data-memory register request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rmf_xd_req_s;
  // Header facts about a received frame, valid with its end pulse
  typedef struct packed {
    logic [2:0] ftype;
    logic ack_req;
    logic dst_present;
    logic addr_match;
    logic src_pan_match;
  } rmf_rx_info_s;
  // Result of one received frame
  typedef struct packed {
    logic done;
    logic accept;
    logic crc_ok;
  } rmf_rx_result_s;
  // Transmit framer states
  typedef enum logic [2:0] {
    RMF_TX_IDLE, RMF_TX_PRE, RMF_TX_SYNC, RMF_TX_DATA, RMF_TX_FCS_LO, RMF_TX_FCS_HI
  } rmf_tx_state_e;
endpackage : rmf_pkg

// file: rmf_tb_modem.sv
// Modulator model on the far side of the transmit framer.
// Assumes the framer holds tx_byte until it is taken.
module rmf_tb_modem #(parameter int GAP = 2) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Framer side
  input wire logic tx_valid,
  output logic tx_take
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = 0; // Stall counter
  // Take one byte after GAP idle cycles, so the framer must hold its byte
  always @(negedge clk_sys or negedge rstn) begin
    if (!rstn || !tx_valid || tx_take) begin
      tx_take <= 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt == GAP) begin
      tx_take <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule // rmf_tb_modem

// file: tb_top.sv
// Self-checking bench for the modem frame control block.
// Assumes rmf_tb_modem consumes transmit bytes on the far side.
`include "rmf_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rmf_pkg::*;
  logic clk_sys, rstn, ce, rx_sfd, rx_byte_valid, rx_end, ss_valid, rx_active;
  logic tx_start, tx_in_valid, tx_in_last, tx_take, rx_q_valid, ack_start;
  logic channel_clear_flag, tx_in_ready, tx_valid, tx_sync_slot, tx_underrun;
  logic [7:0] xd_rdata, rx_byte, rx_q_byte, tx_in_byte, tx_byte;
  logic signed [7:0] signal_strength;
  rmf_xd_req_s xd_req;
  rmf_rx_info_s rx_info;
  rmf_rx_result_s rx_result;
  logic [8:0] tx_seen [$]; // Taken bytes, sync slot in bit 8
  int n_errors = 0;
  int checked = 0;
  rmf_frame_ctrl u_rmf_frame_ctrl (.clk_sys, .rstn, .ce, .xd_req, .xd_rdata, .rx_sfd,
    .rx_byte_valid, .rx_byte, .rx_end, .rx_info, .rx_q_valid, .rx_q_byte, .rx_result,
    .ack_start, .ss_valid, .signal_strength, .rx_active, .channel_clear_flag, .tx_start,
    .tx_in_valid, .tx_in_byte, .tx_in_last, .tx_in_ready, .tx_take, .tx_valid, .tx_byte,
    .tx_sync_slot, .tx_underrun);
  rmf_tb_modem u_rmf_tb_modem (.clk_sys, .rstn, .tx_valid, .tx_take);
  // Clock, 100 ns period
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Log each byte as the modulator takes it
  always @(posedge clk_sys) begin
    if (tx_take && tx_valid) tx_seen.push_back({tx_sync_slot, tx_byte});
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Reflected checksum, zero preset, worked out bit by bit
  function automatic logic [15:0] crcf(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(negedge clk_sys) xd_req = '{ad, d, 1'b1, 1'b0};
    @(negedge clk_sys) xd_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] e);
    @(negedge clk_sys) xd_req = '{ad, 8'h00, 1'b0, 1'b1};
    @(negedge clk_sys) xd_req.rd = 1'b0;
    chk("xd_rdata", e, xd_rdata);
  endtask
  // Reset values, write-back and an unmapped address
  task automatic regs;
    logic [16*19-1:0] a = `RMF_TEST_ADDRS;
    logic [8*19-1:0] v = `RMF_TEST_RSTS;
    rd(16'hDF02, 8'h0A);
    rd(16'hDF03, 8'hE2);
    rd(16'hDF05, 8'hE0);
    rd(`RMF_CTLB_ADDR, `RMF_CTLB_RST);
    for (int i = 0; i < 19; i++) rd(a[16*(18-i) +: 16], v[8*(18-i) +: 8]);
    wr(16'hDF28, 8'h5A);
    rd(16'hDF28, 8'h5A);
    wr(16'hDF36, 8'hFF);
    rd(16'hDF36, 8'h00);
  endtask
  // One received frame, checksum corrupted when ok is 0; dm is destination present, address match
  task automatic rx_frame(input logic [7:0] f, input logic [2:0] ft, input logic [1:0] dm,
    input logic ack, input logic acc, input logic ok);
    logic [15:0] c;
    logic [7:0] b [4];
    c = crcf(crcf(16'h0000, 8'h41), 8'h88);
    b = '{8'h41, 8'h88, c[7:0] ^ {7'h00, !ok}, c[15:8]};
    wr(16'hDF02, f);
    @(negedge clk_sys) rx_sfd = 1;
    @(negedge clk_sys) rx_sfd = 0;
    for (int i = 0; i < 4; i++) begin
      rx_byte_valid = 1;
      rx_byte = b[i];
      @(negedge clk_sys);
      chk("rx_q", {7'h01, b[i]}, {rx_q_valid, rx_q_byte});
    end
    rx_byte_valid = 0;
    rx_end = 1;
    rx_info = '{ft, ack, dm[1], dm[0], dm[0]};
    // Done is a one-cycle pulse: look in the cycle right after the end edge
    @(negedge clk_sys) rx_end = 0;
    chk("rx_result", {1'b1, acc, ok}, rx_result);
  endtask
  // Filter codes, reserved types, decoding off and coordinator role
  task automatic filt;
    logic [7:0] r [9] = '{8'h0A, 8'h0A, 8'h2A, 8'h02, 8'hCA, 8'h4A, 8'h8A, 8'h1A, 8'h0A};
    logic [2:0] t [9] = '{1, 5, 5, 5, 1, 5, 5, 1, 1};
    logic [2:0] m [9] = '{7, 6, 5, 5, 6, 7, 7, 3, 2};
    for (int i = 0; i < 9; i++) rx_frame(r[i], t[i], m[i][2:1], 0, m[i][0], 1);
    rx_frame(8'h0A, 3'd1, 2'b11, 1'b0, 1'b1, 1'b0);
  endtask
  // Reply delay counted in negedges from the one after the frame end edge
  task automatic ack_delay(input logic [7:0] s, input int e);
    int n;
    wr(16'hDF03, 8'hF2);
    wr(`RMF_CTLB_ADDR, s);
    rx_frame(8'h0A, 3'd1, 2'b11, 1'b1, 1'b1, 1'b1);
    for (n = 2; n < 4000 && ack_start !== 1'b1; n++) @(negedge clk_sys);
    chk("ack_delay", e, n);
  endtask
  // Assessment mode 01 below threshold minus hysteresis, then at threshold
  task automatic cca(input logic signed [7:0] s, input logic e);
    @(negedge clk_sys) ss_valid = 1;
    signal_strength = s;
    @(negedge clk_sys) ss_valid = 0;
    @(negedge clk_sys);
    chk("clear_flag", e, channel_clear_flag);
  endtask
  // Compliant three-byte preamble, appended checksum low byte first
  task tx_frame;
    logic [15:0] c;
    logic [8:0] ex [7];
    c = crcf(16'h0000, 8'hA5);
    ex = '{9'h000, 9'h000, 9'h000, 9'h100, 9'h0A5, {1'b0, c[7:0]}, {1'b0, c[15:8]}};
    wr(16'hDF03, 8'hE2);
    tx_seen = {};
    @(negedge clk_sys) tx_start = 1;
    {tx_in_valid, tx_in_last, tx_in_byte} = {2'b11, 8'hA5};
    @(negedge clk_sys) tx_start = 0;
    for (int i = 0; i < 100 && tx_valid === 1'b1; i++) @(negedge clk_sys);
    tx_in_valid = 0;
    chk("tx_count", 7, tx_seen.size());
    for (int i = 0; i < 7; i++) chk("tx_byte", ex[i], tx_seen[i]);
  endtask
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    {rstn, rx_sfd, rx_byte_valid, rx_end, ss_valid, rx_active} = '0;
    {tx_start, tx_in_valid, tx_in_last, rx_byte, tx_in_byte, signal_strength} = '0;
    {xd_req, rx_info} = '0;
    ce = 1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1;
    regs;
    filt;
    ack_delay(8'h30, `RMF_ACK_CYC + 2);
    // Slotted: reply one slot plus one cycle after the SFD edge; frame end lies 5 cycles past it
    ack_delay(8'hB0, `RMF_SLOT_CYC - 2);
    wr(16'hDF03, 8'h62);
    cca(-8'sd35, 1'b1);
    cca(-8'sd32, 1'b0);
    tx_frame;
    end_sim;
  end
  // Watchdog well past the expected run length
  initial begin
    #4_000_000;
    n_errors++;
    end_sim;
  end
endmodule // tb_top
